/* bench/lbm_ctrl_bench.sv */
// lbm_ctrl_bench: self-checking bench for the mode and protection controller.
// assumes lbm_host_model drives the pin and the checker is bound to the design.
`timescale 1ns/1ns
module lbm_ctrl_bench;
  logic mclk, rst_n, ov, fbl, uvlo, otp, cmp, wr, rd, ctrl, irq, gate, ilim, ow, en;
  logic [7:0] addr, vref;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] hmode;
  logic [2:0] gon;
  int err_count, n_tests, r;
  lbm_host_model u_host (.clk_i(mclk), .mode_i(hmode), .high_i(9'h080), .ctrl_o(ctrl));
  lbm_ctrl #(.T_HALF_CYC(300), .STEP_CYC(20)) DUT (
    .MCLK_I(mclk), .RESETN_I(rst_n), .CTRL_PIN_I(ctrl), .SWITCH_NODE_OV_I(ov),
    .FEEDBACK_NODE_LOW_I(fbl), .UVLO_I(uvlo), .OTP_I(otp), .PWM_CMP_I(cmp), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .SW_GATE_O(gate),
    .ILIM_HALF_O(ilim), .VREF_MV_O(vref), .ONE_WIRE_DIMMING_O(ow), .ENABLED_O(en));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // comparator trips a few clocks into each on-time, like a rising inductor current
  always @(posedge mclk) begin
    gon <= gate ? ((gon == 3'h7) ? gon : gon + 3'h1) : 3'h0;
    cmp <= gate && (gon >= 3'h3);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic drive(input logic [1:0] m, input logic [3:0] f);
    @(posedge mclk);
    hmode <= m;
    {ov, fbl, uvlo, otp} <= f;
  endtask : drive
  task automatic reset_dut;
    @(posedge mclk);
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
  endtask : reset_dut
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd_reg
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    @(negedge mclk);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic count_rises(input int n, output int cnt);
    logic last;
    cnt = 0;
    last = gate;
    repeat (n) begin
      @(negedge mclk);
      if (gate && !last) cnt++;
      last = gate;
    end
  endtask : count_rises
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #9_000_000;
    err_count++;
    print_verdict();
  end
  initial begin
    {ov, fbl, uvlo, otp, cmp, wr, rd, rst_n} = 8'h00;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    hmode = 2'h0;
    gon = 3'h0;
    err_count = 0;
    n_tests = 0;
    reset_dut();
    rd_reg(8'h08, rv);
    chk("mask reset", 32'h0000_0000, rv);
    rd_reg(8'h0C, rv);
    chk("step reset", 32'h0000_001F, rv);
    rd_reg(8'h20, rv);
    chk("unmapped", 32'h0000_0000, rv);
    wr_reg(8'h0C, 32'h0000_0005);
    rd_reg(8'h0C, rv);
    chk("step rw", 32'h0000_0005, rv);
    $display("test registers done");
    drive(2'h1, 4'h0);
    cyc(8);
    chk("enabled", 32'h0000_0001, en);
    chk("pwm mode", 32'h0000_0000, ow);
    chk("half limit", 32'h0000_0001, ilim);
    cyc(300);
    chk("full limit", 32'h0000_0000, ilim);
    chk("ramp step 15", 32'h0000_005D, vref);
    cyc(400);
    chk("ramp end", 32'h0000_00C8, vref);
    rd_reg(8'h10, rv);
    chk("vref reg", 32'h0000_00C8, rv);
    rd_reg(8'h04, rv);
    chk("status ramp", 32'h0000_0020, rv);
    count_rises(160, r);
    chk("gate rises", 32'h0000_000A, r);
    $display("test soft start done");
    drive(2'h2, 4'h0);
    cyc(12400);
    chk("pwm half", 32'h0000_0064, vref);
    chk("mode kept", 32'h0000_0000, ow);
    rd_reg(8'h00, rv);
    chk("state pwm", 32'h0000_0001, rv & 32'hFFFF_FFFB);
    $display("test pwm done");
    wr_reg(8'h08, 32'h0000_0010);
    drive(2'h0, 4'h0);
    cyc(25020);
    chk("pin off", 32'h0000_0000, en);
    chk("gate idle", 32'h0000_0000, gate);
    chk("irq up", 32'h0000_0001, irq);
    rd_reg(8'h04, rv);
    chk("status off", 32'h0000_0010, rv);
    chk("irq cleared", 32'h0000_0000, irq);
    $display("test shutdown done");
    drive(2'h1, 4'h0);
    cyc(10);
    chk("re-enabled", 32'h0000_0001, en);
    drive(2'h1, 4'hC);
    cyc(150);
    chk("open latch", 32'h0000_0000, en);
    chk("irq masked", 32'h0000_0000, irq);
    drive(2'h1, 4'h0);
    cyc(500);
    chk("stays latched", 32'h0000_0000, en);
    chk("latched gate", 32'h0000_0000, gate);
    rd_reg(8'h04, rv);
    chk("status open", 32'h0000_0001, rv);
    drive(2'h0, 4'h0);
    cyc(20);
    drive(2'h1, 4'h0);
    cyc(10);
    chk("toggle restart", 32'h0000_0001, en);
    $display("test open string done");
    for (int i = 0; i < 2; i++) begin
      drive(2'h1, 4'h2 >> i);
      cyc(6);
      chk("fault off", 32'h0000_0000, en);
      chk("fault gate", 32'h0000_0000, gate);
      drive(2'h1, 4'h0);
      cyc(10);
      chk("fault restart", 32'h0000_0001, en);
    end
    rd_reg(8'h04, rv);
    chk("status faults", 32'h0000_0006, rv);
    $display("test faults done");
    drive(2'h0, 4'h0);
    reset_dut();
    rd_reg(8'h0C, rv);
    chk("step after reset", 32'h0000_001F, rv);
    drive(2'h1, 4'h0);
    cyc(1100);
    drive(2'h0, 4'h0);
    cyc(2640);
    chk("one-wire at once", 32'h0000_0001, ow);
    cyc(60);
    drive(2'h1, 4'h0);
    cyc(8000);
    chk("one-wire kept", 32'h0000_0001, ow);
    rd_reg(8'h04, rv);
    chk("status one-wire", 32'h0000_0028, rv);
    wr_reg(8'h0C, 32'h0000_000D);
    cyc(2);
    chk("one-wire step", 32'h0000_002C, vref);
    $display("test one-wire done");
    drive(2'h0, 4'h0);
    reset_dut();
    drive(2'h1, 4'h0);
    cyc(500);
    drive(2'h0, 4'h0);
    cyc(2700);
    drive(2'h1, 4'h0);
    cyc(10);
    chk("early low ignored", 32'h0000_0000, ow);
    $display("test early low done");
    drive(2'h0, 4'h0);
    reset_dut();
    drive(2'h1, 4'h0);
    cyc(8000);
    drive(2'h0, 4'h0);
    cyc(2700);
    drive(2'h1, 4'h0);
    cyc(10);
    chk("late low ignored", 32'h0000_0000, ow);
    $display("test late low done");
    print_verdict();
  end
endmodule : lbm_ctrl_bench

/* bench/lbm_ctrl_checker.sv */
// lbm_ctrl_checker: port-level assertions for the mode and protection controller.
// assumes it is bound to lbm_ctrl and sees only its ports.
`timescale 1ns/1ns
module lbm_ctrl_checker #(
  parameter int T_OFF_CYC = 25000,
  parameter int T_HALF_CYC = 50000
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic CTRL_PIN_I,
  input wire logic SWITCH_NODE_OV_I,
  input wire logic FEEDBACK_NODE_LOW_I,
  input wire logic UVLO_I,
  input wire logic OTP_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic SW_GATE_O,
  input wire logic ILIM_HALF_O,
  input wire logic [7:0] VREF_MV_O,
  input wire logic ONE_WIRE_DIMMING_O,
  input wire logic ENABLED_O
);
  // sync, eight ticks of 16 clocks, latch, plus margin
  localparam int OV_WAIT = 140;
  int lowc_r, ovc_r, hc_r, lowc_nxt, ovc_nxt, hc_nxt;
  always_comb begin
    lowc_nxt = CTRL_PIN_I ? 0 : lowc_r + 1;
    ovc_nxt = (SWITCH_NODE_OV_I && FEEDBACK_NODE_LOW_I) ? ovc_r + 1 : 0;
    hc_nxt = ILIM_HALF_O ? hc_r + 1 : 0;
  end
  always_ff @(posedge MCLK_I) begin
    lowc_r <= RESETN_I ? lowc_nxt : 0;
    ovc_r <= RESETN_I ? ovc_nxt : 0;
    hc_r <= RESETN_I ? hc_nxt : 0;
  end
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);
  property p_enable;
    $rose(CTRL_PIN_I) && !ENABLED_O && !UVLO_I && !OTP_I ##1 (CTRL_PIN_I && !UVLO_I && !OTP_I) [*3] |-> ENABLED_O;
  endproperty
  a_enable: assert property (p_enable) else $error("no enable after pin rise");
  property p_gate_off;
    !ENABLED_O && !$past(ENABLED_O) |-> !SW_GATE_O;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate active while off");
  property p_pin_off;
    lowc_r > T_OFF_CYC + 5 |-> !ENABLED_O;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("no shutdown on long low pin");
  property p_uvlo;
    UVLO_I [*4] |-> !ENABLED_O;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("running under undervoltage");
  property p_otp;
    OTP_I [*4] |-> !ENABLED_O;
  endproperty
  a_otp: assert property (p_otp) else $error("running while overheated");
  property p_open;
    ovc_r > OV_WAIT |-> !ENABLED_O;
  endproperty
  a_open: assert property (p_open) else $error("no open string shutdown");
  property p_ilim;
    $fell(ILIM_HALF_O) && ENABLED_O |-> hc_r >= T_HALF_CYC - 1 && hc_r <= T_HALF_CYC + 1;
  endproperty
  a_ilim: assert property (p_ilim) else $error("half limit period wrong");
  property p_vref_start;
    $rose(ENABLED_O) |=> VREF_MV_O == 8'h00 ##1 VREF_MV_O == 8'h00;
  endproperty
  a_vref_start: assert property (p_vref_start) else $error("ramp not from zero");
  property p_mode_fixed;
    ENABLED_O && $past(ENABLED_O) && $past(ONE_WIRE_DIMMING_O) |-> ONE_WIRE_DIMMING_O;
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed while on");
  property p_rdata;
    !$past(RD_I) |-> RDATA_O == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read slot");
  c_enable: cover property ($rose(ENABLED_O));
  c_one_wire: cover property ($rose(ONE_WIRE_DIMMING_O));
  c_open: cover property (ovc_r > OV_WAIT);
endmodule : lbm_ctrl_checker

bind lbm_ctrl lbm_ctrl_checker #(.T_OFF_CYC(T_OFF_CYC), .T_HALF_CYC(T_HALF_CYC)) u_lbm_chk (
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .CTRL_PIN_I(CTRL_PIN_I), .SWITCH_NODE_OV_I(SWITCH_NODE_OV_I),
  .FEEDBACK_NODE_LOW_I(FEEDBACK_NODE_LOW_I), .UVLO_I(UVLO_I), .OTP_I(OTP_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .SW_GATE_O(SW_GATE_O), .ILIM_HALF_O(ILIM_HALF_O), .VREF_MV_O(VREF_MV_O),
  .ONE_WIRE_DIMMING_O(ONE_WIRE_DIMMING_O), .ENABLED_O(ENABLED_O));

/* bench/lbm_host_model.sv */
// lbm_host_model: host side of the control pin: low, high or pwm dimming.
// assumes the bench picks the mode; pin changes only after a rising clock edge.
`timescale 1ns/1ns
module lbm_host_model (
  input wire logic clk_i,
  input wire logic [1:0] mode_i,
  input wire logic [8:0] high_i,
  output logic ctrl_o
);
  logic [7:0] ph_r;
  initial begin
    ph_r = 8'h00;
    ctrl_o = 1'b0;
  end
  // 256-clock period, about 39 kHz, well inside the dimming band
  always @(posedge clk_i) begin
    ph_r <= ph_r + 8'h01;
    case (mode_i)
      2'h0: ctrl_o <= 1'b0;
      2'h1: ctrl_o <= 1'b1;
      default: ctrl_o <= ({1'b0, ph_r} < high_i);
    endcase
  end
endmodule : lbm_host_model

/* hw/lbm_ctrl.sv */
// lbm_ctrl: enable, dimming mode choice, soft start, protection and
// reference generation for a boost white-LED driver, plus a register port.
// assumes analog status inputs are asynchronous and the loop itself is external.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "lbm_params.svh"

// How it works
// RULE1 - reference ramps from zero to target in 32 equal 213 us steps
// RULE2 - current limit halved for the first 5 ms of start-up
// RULE3 - switch high plus feedback low for 8 switching cycles shuts down
// RULE4 - open-LED shutdown stays latched until the control pin toggles
// RULE5 - mode chosen anew at each enable; PWM unless one-wire pattern seen
// RULE6 - pin rising edge enables and opens the detection window
// RULE7 - host waits 100 us after rising, then holds low over 260 us
// RULE8 - qualifying low must finish inside the 1 ms window, else PWM
// RULE9 - one-wire mode taken at once, before the window closes
// RULE10 - mode stays fixed until shutdown and fresh start-up
// RULE11 - pin low over 2.5 ms shuts down; switch idle in shutdown
// RULE12 - undervoltage holds shutdown with switch off, restarts on release
// RULE13 - over-temperature shuts down, restarts by itself when it clears
// RULE14 - PWM mode reference is duty times 200 mV, full when pin high
// RULE15 - fixed 600 kHz switching (code divides 10 MHz by 16, giving 625 kHz); comparator ends each on-time
// RULE16 - one-wire step defaults to full scale, back to it on reset
// RULE17 - host keeps PWM dimming between 5 kHz and 100 kHz
// RULE18 - control pin synchronised, all durations counted on the clock
// RULE19 - normal current limit restored after the halved period
module lbm_ctrl #(
  parameter int T_OFF_CYC = `LBM_OFF_CYC,
  parameter int T_WIN_CYC = `LBM_WIN_CYC,
  parameter int T_HALF_CYC = `LBM_HALF_CYC,
  parameter int STEP_CYC = `LBM_STEP_CYC,
  parameter int AW = 8
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic CTRL_PIN_I,
  input wire logic SWITCH_NODE_OV_I,
  input wire logic FEEDBACK_NODE_LOW_I,
  input wire logic UVLO_I,
  input wire logic OTP_I,
  input wire logic PWM_CMP_I,
  input wire logic [AW-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic IRQ_O,
  output logic SW_GATE_O,
  output logic ILIM_HALF_O,
  output logic [7:0] VREF_MV_O,
  output logic ONE_WIRE_DIMMING_O,
  output logic ENABLED_O
);
  localparam logic [7:0] STEP_MV [32] = '{
    8'h00, 8'h05, 8'h08, 8'h0B, 8'h0E, 8'h11, 8'h14, 8'h17,
    8'h1A, 8'h1D, 8'h20, 8'h23, 8'h26, 8'h2C, 8'h32, 8'h38,
    8'h3E, 8'h44, 8'h4A, 8'h50, 8'h56, 8'h5C, 8'h62, 8'h68,
    8'h74, 8'h80, 8'h8C, 8'h98, 8'hA4, 8'hB0, 8'hBC, 8'hC8};
  localparam int PW = `LBM_PWM_WIN_LOG2;

  // pin synchronisation
  logic [5:0] pins_s;
  logic ctrl_s, ov_s, fbl_s, uvlo_s, otp_s, cmp_s;
  logic ctrl_d_r;
  logic rise, fall, fault;

  lbm_sync #(.WIDTH(6)) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .d_i({PWM_CMP_I, OTP_I, UVLO_I, FEEDBACK_NODE_LOW_I, SWITCH_NODE_OV_I, CTRL_PIN_I}), // RULE18
    .q_o(pins_s)
  );
  assign {cmp_s, otp_s, uvlo_s, fbl_s, ov_s, ctrl_s} = pins_s;
  // reset value 0 lets a pin already high at power-up count as a rising edge
  assign rise = ctrl_s && !ctrl_d_r; // RULE6
  assign fall = !ctrl_s && ctrl_d_r;
  assign fault = uvlo_s || otp_s;

  // time bases
  logic osc_tick, ss_tick, ss_clr;

  lbm_tick #(.DIV(`LBM_OSC_DIV)) u_osc_tick (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .clr_i(1'b0),
    .tick_o(osc_tick) // RULE15
  );
  lbm_tick #(.DIV(STEP_CYC)) u_ss_tick (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .clr_i(ss_clr),
    .tick_o(ss_tick) // RULE1
  );

  // sequencer state
  lbm_pkg::lbm_state_t state_r, state_nxt;
  logic [19:0] lo_r, lo_nxt;
  logic [19:0] win_r, win_nxt;
  logic [19:0] half_r, half_nxt;
  logic [5:0] ss_r, ss_nxt;
  logic [3:0] ov_r, ov_nxt;
  logic det_r, det_nxt;
  logic qual_r, qual_nxt;
  logic wire_r, wire_nxt;
  logic [`LBM_IRQ_W-1:0] ev;

  always_comb begin
    state_nxt = state_r;
    lo_nxt = ctrl_s ? 20'h0_0000 : ((lo_r == 20'hF_FFFF) ? lo_r : lo_r + 20'h0_0001); // RULE18
    win_nxt = det_r ? win_r + 20'h0_0001 : win_r;
    half_nxt = half_r;
    ss_nxt = ss_r;
    ov_nxt = ov_r;
    det_nxt = det_r;
    qual_nxt = qual_r;
    wire_nxt = wire_r;
    ss_clr = 1'b0;
    ev = '0;
    case (state_r)
      lbm_pkg::ST_OFF, lbm_pkg::ST_LATCH: begin
        // a fresh enable re-arms everything, including the mode
        if (rise && fault) begin
          // an enable seen during a fault waits for the fault to clear
          state_nxt = lbm_pkg::ST_FAULT; // RULE12 RULE13
        end else if (rise) begin // RULE4
          state_nxt = lbm_pkg::ST_ON;
          win_nxt = 20'h0_0000;
          det_nxt = 1'b1; // RULE6
          qual_nxt = 1'b0;
          wire_nxt = 1'b0; // RULE5
          ss_nxt = 6'h00;
          half_nxt = 20'h0_0000;
          ov_nxt = 4'h0;
          ss_clr = 1'b1;
        end
      end
      lbm_pkg::ST_ON: begin
        if (fault) begin
          state_nxt = lbm_pkg::ST_FAULT; // RULE12 RULE13
          ev[`LBM_IRQ_UVLO] = uvlo_s;
          ev[`LBM_IRQ_OTP] = otp_s;
        end else if (lo_r > 20'(T_OFF_CYC)) begin
          state_nxt = lbm_pkg::ST_OFF; // RULE11
          ev[`LBM_IRQ_OFF] = 1'b1;
        end else if (ov_r == `LBM_OV_CYCLES) begin
          state_nxt = lbm_pkg::ST_LATCH; // RULE3
          ev[`LBM_IRQ_OPEN] = 1'b1;
        end else begin
          if (det_r) begin
            if (win_r >= 20'(T_WIN_CYC)) begin
              det_nxt = 1'b0; // RULE8
            end else if (qual_r && !ctrl_s && lo_r > 20'(`LBM_DET_CYC)) begin
              wire_nxt = 1'b1; // RULE9
              det_nxt = 1'b0;
              ev[`LBM_IRQ_WIRE] = 1'b1;
            end else if (fall) begin
              // a low that starts before the delay never qualifies
              qual_nxt = (win_r >= 20'(`LBM_DLY_CYC)); // RULE7
            end
          end
          if (ss_tick && ss_r != 6'(`LBM_SS_STEPS)) begin
            ss_nxt = ss_r + 6'h01; // RULE1
            ev[`LBM_IRQ_SSDONE] = (ss_r == 6'(`LBM_SS_STEPS - 1));
          end
          if (half_r != 20'(T_HALF_CYC)) begin
            half_nxt = half_r + 20'h0_0001; // RULE2 RULE19
          end
          if (osc_tick) begin
            ov_nxt = (ov_s && fbl_s) ? ov_r + 4'h1 : 4'h0; // RULE3
          end
        end
      end
      lbm_pkg::ST_FAULT: begin
        if (!fault) begin
          if (ctrl_s) begin
            // automatic restart: soft start and mode choice run again
            state_nxt = lbm_pkg::ST_ON; // RULE12 RULE13
            win_nxt = 20'h0_0000;
            det_nxt = 1'b1;
            qual_nxt = 1'b0;
            wire_nxt = 1'b0;
            ss_nxt = 6'h00;
            half_nxt = 20'h0_0000;
            ov_nxt = 4'h0;
            ss_clr = 1'b1;
          end else begin
            state_nxt = lbm_pkg::ST_OFF;
          end
        end
      end
      default: state_nxt = lbm_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      state_r <= lbm_pkg::ST_OFF;
      ctrl_d_r <= 1'b0;
      lo_r <= 20'h0_0000;
      win_r <= 20'h0_0000;
      half_r <= 20'h0_0000;
      ss_r <= 6'h00;
      ov_r <= 4'h0;
      det_r <= 1'b0;
      qual_r <= 1'b0;
      wire_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_d_r <= ctrl_s;
      lo_r <= lo_nxt;
      win_r <= win_nxt;
      half_r <= half_nxt;
      ss_r <= ss_nxt;
      ov_r <= ov_nxt;
      det_r <= det_nxt;
      qual_r <= qual_nxt;
      wire_r <= wire_nxt; // RULE10
    end
  end

  // PWM duty measurement over a fixed window instead of a divider
  logic [PW-1:0] pm_cnt_r, pm_cnt_nxt;
  logic [PW:0] hi_acc_r, hi_acc_nxt;
  logic [7:0] pwm_ref_r, pwm_ref_nxt;
  logic [PW:0] hi_sum;
  logic [PW+8:0] pwm_prod;

  always_comb begin
    hi_sum = hi_acc_r + (PW + 1)'(ctrl_s);
    pwm_prod = hi_sum * `LBM_REF_FULL_MV;
    pm_cnt_nxt = pm_cnt_r + PW'(1);
    hi_acc_nxt = hi_sum;
    pwm_ref_nxt = pwm_ref_r;
    if (pm_cnt_r == {PW{1'b1}}) begin
      // steady high gives exactly full scale
      pwm_ref_nxt = pwm_prod[PW+7:PW]; // RULE14
      hi_acc_nxt = '0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      pm_cnt_r <= '0;
      hi_acc_r <= '0;
      pwm_ref_r <= `LBM_REF_FULL_MV;
    end else begin
      pm_cnt_r <= pm_cnt_nxt;
      hi_acc_r <= hi_acc_nxt;
      pwm_ref_r <= pwm_ref_nxt;
    end
  end

  // reference, gate and current limit outputs
  logic [4:0] step_r, step_nxt;
  logic [7:0] target;
  logic [13:0] ramp_prod;
  logic [7:0] vref_r, vref_nxt;
  logic gate_r, gate_nxt;
  logic half_lim_r, half_lim_nxt;
  logic run;

  assign run = (state_r == lbm_pkg::ST_ON);

  always_comb begin
    target = wire_r ? STEP_MV[step_r] : pwm_ref_r; // RULE14
    ramp_prod = target * ss_r;
    vref_nxt = run ? ramp_prod[12:5] : 8'h00; // RULE1
    half_lim_nxt = run && (half_r != 20'(T_HALF_CYC)); // RULE2 RULE19
    if (!run) begin
      gate_nxt = 1'b0; // RULE11 RULE12
    end else if (osc_tick) begin
      gate_nxt = 1'b1; // RULE15
    end else if (cmp_s) begin
      gate_nxt = 1'b0; // RULE15
    end else begin
      gate_nxt = gate_r;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      vref_r <= 8'h00;
      gate_r <= 1'b0;
      half_lim_r <= 1'b0;
    end else begin
      vref_r <= vref_nxt;
      gate_r <= gate_nxt;
      half_lim_r <= half_lim_nxt;
    end
  end

  // register port
  logic [`LBM_IRQ_W-1:0] stat_r, stat_nxt;
  logic [`LBM_IRQ_W-1:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rd_stat;

  assign rd_stat = RD_I && (ADDR_I == AW'(`LBM_A_IRQ_STAT));

  always_comb begin
    // an event in the clearing read's cycle survives into the new status
    stat_nxt = (rd_stat ? '0 : stat_r) | ev;
    mask_nxt = mask_r;
    step_nxt = step_r;
    if (WR_I && ADDR_I == AW'(`LBM_A_IRQ_MASK)) begin
      mask_nxt = WDATA_I[`LBM_IRQ_W-1:0];
    end
    // the one-wire decoder lives elsewhere; software loads the step here
    if (WR_I && ADDR_I == AW'(`LBM_A_WIRE_STEP)) begin
      step_nxt = WDATA_I[4:0];
    end
    rdata_nxt = 32'h0000_0000;
    if (RD_I) begin
      case (ADDR_I)
        AW'(`LBM_A_STATE): rdata_nxt = {26'h000_0000, half_lim_r, wire_r, det_r, gate_r, state_r};
        AW'(`LBM_A_IRQ_STAT): rdata_nxt = {26'h000_0000, stat_r};
        AW'(`LBM_A_IRQ_MASK): rdata_nxt = {26'h000_0000, mask_r};
        AW'(`LBM_A_WIRE_STEP): rdata_nxt = {27'h000_0000, step_r};
        AW'(`LBM_A_VREF): rdata_nxt = {24'h00_0000, vref_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      stat_r <= '0;
      mask_r <= `LBM_MASK_RST;
      step_r <= `LBM_STEP_RST; // RULE16
      rdata_r <= 32'h0000_0000;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      step_r <= step_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_O = rdata_r;
  assign IRQ_O = |(stat_r & mask_r);
  assign SW_GATE_O = gate_r;
  assign ILIM_HALF_O = half_lim_r;
  assign VREF_MV_O = vref_r;
  assign ONE_WIRE_DIMMING_O = wire_r;
  assign ENABLED_O = run;
endmodule : lbm_ctrl

/* hw/lbm_params.svh */
// lbm_params.svh: offsets, field positions, reset values and timing counts
// of the LED boost mode and protection controller.
// assumes a 10 MHz core clock; every clock-cycle count below is derived from it.
`ifndef LBM_PARAMS_SVH
`define LBM_PARAMS_SVH

`define LBM_CLK_KHZ 10000
// switching clock
`define LBM_OSC_KHZ 600
`define LBM_OSC_DIV (`LBM_CLK_KHZ / `LBM_OSC_KHZ)
// soft start
`define LBM_SS_STEPS 32
`define LBM_STEP_US 213
`define LBM_STEP_CYC ((`LBM_STEP_US * `LBM_CLK_KHZ + 999) / 1000)
`define LBM_HALF_MS 5
`define LBM_HALF_CYC (`LBM_HALF_MS * `LBM_CLK_KHZ)
// pin timing
`define LBM_OFF_US 2500
`define LBM_OFF_CYC ((`LBM_OFF_US * `LBM_CLK_KHZ + 999) / 1000)
`define LBM_DLY_US 100
`define LBM_DLY_CYC ((`LBM_DLY_US * `LBM_CLK_KHZ + 999) / 1000)
`define LBM_DET_US 260
`define LBM_DET_CYC ((`LBM_DET_US * `LBM_CLK_KHZ + 999) / 1000)
`define LBM_WIN_US 1000
`define LBM_WIN_CYC ((`LBM_WIN_US * `LBM_CLK_KHZ) / 1000)
// open LED filter, in switching cycles
`define LBM_OV_CYCLES 4'h8
// reference
`define LBM_REF_FULL_MV 8'hC8
`define LBM_PWM_WIN_LOG2 12
// register offsets
`define LBM_A_STATE 8'h00
`define LBM_A_IRQ_STAT 8'h04
`define LBM_A_IRQ_MASK 8'h08
`define LBM_A_WIRE_STEP 8'h0C
`define LBM_A_VREF 8'h10
// interrupt bit positions
`define LBM_IRQ_OPEN 0
`define LBM_IRQ_UVLO 1
`define LBM_IRQ_OTP 2
`define LBM_IRQ_WIRE 3
`define LBM_IRQ_OFF 4
`define LBM_IRQ_SSDONE 5
`define LBM_IRQ_W 6
// reset values
`define LBM_STEP_RST 5'h1F
`define LBM_MASK_RST 6'h00

`endif

/* hw/lbm_pkg.sv */
// lbm_pkg: types of the LED boost mode and protection controller.
// assumes nothing beyond a SystemVerilog compiler.
package lbm_pkg;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON,
    ST_FAULT,
    ST_LATCH
  } lbm_state_t;
endpackage : lbm_pkg

/* hw/lbm_sync.sv */
// lbm_sync: two flip-flop synchroniser for a group of pin inputs.
// assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ns
module lbm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule : lbm_sync

/* hw/lbm_tick.sv */
// lbm_tick: divider giving a one-cycle enable pulse every DIV clocks.
// assumes clr_i restarts the period so the first pulse lands DIV clocks later.
`timescale 1ns/1ns
module lbm_tick #(
  parameter int DIV = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  output logic tick_o
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  assign tick_o = (cnt_r == CW'(DIV - 1));

  always_comb begin
    if (clr_i || tick_o) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : lbm_tick
